/* File: hdl/vcat_pkg.sv */
// package: register map, field positions and shared types for the vc arbitration table regs
package vcat_pkg;

  // register byte offsets
  localparam logic [11:0] VCAT_CTRL_OFS = 12'h0114; // vc_resource_control
  localparam logic [11:0] VCAT_STAT_OFS = 12'h0118; // vc_resource_status
  localparam logic [11:0] VCAT_TBL0_OFS = 12'h0120; // arbitration_table_word0

  // control field positions
  localparam int VCAT_LOAD_BIT = 16; // load_table_request
  localparam int VCAT_SEL_LO = 17; // arbitration select, low bit
  localparam int VCAT_SEL_HI = 19; // arbitration select, high bit
  localparam int VCAT_CHANNEL_IDENTIFIER_LO = 24; // channel_identifier low bit
  localparam int VCAT_EN_BIT = 31; // channel_enable_bit

  // status field positions
  localparam int VCAT_COH_BIT = 0; // table_coherency_flag
  localparam int VCAT_NEG_BIT = 1; // negotiation_pending_flag

  // hardwired and reset values
  localparam logic [2:0] VCAT_CHANNEL_IDENTIFIER_VAL = 3'h0;
  localparam logic VCAT_EN_VAL = 1'b1;
  localparam logic [7:0] VCAT_MAP_RST = 8'hff; // tc map after reset
  localparam logic [2:0] VCAT_SEL_RST = 3'h0;
  localparam logic [1:0] VCAT_PHASE_RST = 2'h0; // upstream port
  localparam logic [31:0] VCAT_ZERO = 32'h0000_0000;

  // table geometry: five 2-bit phases in word 0
  localparam int VCAT_PHASES = 5;
  localparam int VCAT_PW = 2;
  localparam int VCAT_TBL_W = VCAT_PHASES * VCAT_PW;

  // phase encodings
  localparam logic [1:0] VCAT_PORT_A = 2'h0;
  localparam logic [1:0] VCAT_PORT_B = 2'h1;
  localparam logic [1:0] VCAT_PORT_C = 2'h2;
  localparam logic [1:0] VCAT_PORT_RSV = 2'h3;

  // software port signals travel together
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vcat_req_t;

  // one port grant from the arbiter
  typedef struct packed {
    logic valid;
    logic [1:0] port;
  } vcat_grant_t;

endpackage

/* File: hdl/vcat_sync.sv */
// two-flop synchroniser for a level from outside the clock domain
`timescale 1ns/10ps
module vcat_sync
  import vcat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_reg; // first stage, read only by the second

  // both stages clear on reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: hdl/vcat_arbiter.sv */
// phase walker: serves the latched table, skipping invalid entries
`timescale 1ns/10ps
module vcat_arbiter
  import vcat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [VCAT_TBL_W-1:0] table_in,
  input wire logic load,
  input wire logic [1:0] egress_port,
  input wire logic advance,
  output logic load_done,
  output vcat_grant_t grant
);

  logic [VCAT_TBL_W-1:0] table_reg; // latched table
  logic [2:0] phase_reg; // current phase
  logic [2:0] phase_next;
  logic [1:0] cur_port;

  // an entry is usable if it names a real port other than egress
  function automatic logic entry_ok(input logic [1:0] p, input logic [1:0] eg);
    entry_ok = (p != VCAT_PORT_RSV) && (p != eg);
  endfunction

  function automatic logic [2:0] wrap_inc(input logic [2:0] p);
    wrap_inc = (p == 3'(VCAT_PHASES - 1)) ? 3'h0 : p + 3'h1;
  endfunction

  assign cur_port = table_reg[phase_reg*VCAT_PW +: VCAT_PW];

  // whole table latched in one edge, so done follows load by one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      table_reg <= '0;
      load_done <= 1'b0;
    end else begin
      load_done <= load;
      if (load) begin
        table_reg <= table_in;
      end
    end
  end

  // invalid entries step on at the next edge even without advance, each costing one cycle with no grant
  always_comb begin
    phase_next = phase_reg;
    if (!entry_ok(cur_port, egress_port) || advance) begin
      phase_next = wrap_inc(phase_reg);
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst || load) begin
      phase_reg <= 3'h0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // grant is registered; decode per encoding
  always_ff @(posedge core_clk) begin
    if (rst) begin
      grant <= '0;
    end else begin
      grant.valid <= entry_ok(cur_port, egress_port);
      grant.port <= cur_port;
    end
  end

endmodule

/* File: hdl/vcat_regs.sv */
// top: register bank for the single vc resource and its port arbitration table
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
module vcat_regs
  import vcat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic fc_init_pending,
  input wire logic [1:0] egress_port,
  input wire logic arb_advance,
  output logic grant_valid,
  output logic [1:0] grant_port
);

  vcat_req_t req; // bundled software access
  logic [7:0] map_reg; // tc map, bit 0 fixed
  logic [2:0] sel_reg; // arbitration select
  logic [VCAT_TBL_W-1:0] tbl_reg; // phase fields
  logic coh_reg; // table_coherency_flag
  logic load_pend_reg; // load issued, not yet latched
  logic neg_sync; // synchronised fc pending
  logic load_pulse;
  logic load_done;
  logic tbl_wr;
  logic ctrl_wr;
  logic [31:0] rdata_next;
  vcat_grant_t grant;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // address hit helper, used by both write and read decode
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  assign ctrl_wr = req.wr && hit(req.addr, VCAT_CTRL_OFS);
  assign tbl_wr = req.wr && hit(req.addr, VCAT_TBL0_OFS);
  // writing zero to the load bit does nothing
  assign load_pulse = ctrl_wr && req.wdata[VCAT_LOAD_BIT];

  // flow-control pending arrives from another domain
  vcat_sync u_neg_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(fc_init_pending),
    .sync_out(neg_sync)
  );

  // control fields; id and enable are constants, never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      map_reg <= VCAT_MAP_RST;
      sel_reg <= VCAT_SEL_RST;
    end else if (ctrl_wr) begin
      map_reg <= {req.wdata[7:1], 1'b1};
      sel_reg <= req.wdata[VCAT_SEL_HI:VCAT_SEL_LO];
    end
  end

  // phase fields: full read/write, reset to upstream port
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tbl_reg <= {VCAT_PHASES{VCAT_PHASE_RST}};
    end else if (tbl_wr) begin
      tbl_reg <= req.wdata[VCAT_TBL_W-1:0];
    end
  end

  // coherency flag: table write sets it and wins over a completing load
  always_ff @(posedge core_clk) begin
    if (rst) begin
      coh_reg <= 1'b0;
    end else if (tbl_wr) begin
      coh_reg <= 1'b1;
    end else if (load_done && load_pend_reg) begin
      coh_reg <= 1'b0;
    end
  end

  // track an outstanding load until the arbiter confirms latch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      load_pend_reg <= 1'b0;
    end else if (load_pulse) begin
      load_pend_reg <= 1'b1;
    end else if (load_done) begin
      load_pend_reg <= 1'b0;
    end
  end

  // arbiter copy; flag is kept even when select uses no table
  vcat_arbiter u_arb (
    .core_clk(core_clk),
    .rst(rst),
    .table_in(tbl_reg),
    .load(load_pulse),
    .egress_port(egress_port),
    .advance(arb_advance),
    .load_done(load_done),
    .grant(grant)
  );

  assign grant_valid = grant.valid;
  assign grant_port = grant.port;

  // read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = VCAT_ZERO;
    if (hit(req.addr, VCAT_CTRL_OFS)) begin
      rdata_next[7:0] = map_reg;
      rdata_next[VCAT_SEL_HI:VCAT_SEL_LO] = sel_reg;
      rdata_next[VCAT_LOAD_BIT] = 1'b0;
      rdata_next[VCAT_CHANNEL_IDENTIFIER_LO +: 3] = VCAT_CHANNEL_IDENTIFIER_VAL;
      rdata_next[VCAT_EN_BIT] = VCAT_EN_VAL;
    end else if (hit(req.addr, VCAT_STAT_OFS)) begin
      rdata_next[VCAT_COH_BIT] = coh_reg;
      rdata_next[VCAT_NEG_BIT] = neg_sync;
    end else if (hit(req.addr, VCAT_TBL0_OFS)) begin
      rdata_next[VCAT_TBL_W-1:0] = tbl_reg;
    end
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= VCAT_ZERO;
    end else if (req.rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= VCAT_ZERO;
    end
  end

endmodule

/* File: test/vcat_regs_chk.sv */
// checker: port-level assertions for the vc arbitration table regs
`timescale 1ns/10ps
module vcat_regs_chk
  import vcat_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic fc_init_pending,
  input wire logic [1:0] egress_port,
  input wire logic arb_advance,
  input wire logic grant_valid,
  input wire logic [1:0] grant_port
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // decoded requests, named once to keep the properties short
  wire rd_ctl = reg_rd && reg_addr == VCAT_CTRL_OFS;
  wire rd_st = reg_rd && reg_addr == VCAT_STAT_OFS;
  wire rd_tb = reg_rd && reg_addr == VCAT_TBL0_OFS;
  wire wr_tb = reg_wr && reg_addr == VCAT_TBL0_OFS;
  wire wr_ld = reg_wr && reg_addr == VCAT_CTRL_OFS && reg_wdata[VCAT_LOAD_BIT];

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == VCAT_ZERO)
    else $error("read data not zero outside read slot");
  a_ctrl_fixed: assert property (rd_ctl |=> reg_rdata[31] && reg_rdata[0] &&
    reg_rdata[30:20] == 11'h000 && reg_rdata[16:8] == 9'h000)
    else $error("control fixed fields wrong");
  a_stat_resv: assert property (rd_st |=> reg_rdata[31:2] == 30'h0000_0000)
    else $error("status reserved bits not zero");
  // the level crosses a two-flop synchroniser, so give it four steady cycles
  a_neg_flag: assert property ($stable(fc_init_pending)[*4] ##0 rd_st |=>
    reg_rdata[1] == $past(fc_init_pending))
    else $error("negotiation flag does not follow input");
  a_coh_set: assert property (wr_tb ##1 rd_st |=> reg_rdata[0])
    else $error("coherency flag not set by table write");
  a_coh_hold: assert property (wr_tb ##1 (!wr_ld)[*4] ##0 rd_st |=> reg_rdata[0])
    else $error("coherency flag dropped without load");
  a_load_clr: assert property (wr_ld ##1 !reg_wr ##1 (!reg_wr && rd_st) |=>
    !reg_rdata[0])
    else $error("coherency flag not cleared after load");
  a_tbl_back: assert property (wr_tb ##1 rd_tb |=>
    reg_rdata == {22'h00_0000, $past(reg_wdata[9:0], 2)})
    else $error("table word readback wrong");
  a_grant_legal: assert property (grant_valid |->
    grant_port != VCAT_PORT_RSV && grant_port != egress_port)
    else $error("grant to invalid port");
  a_reset_quiet: assert property ($past(rst) |-> reg_rdata == VCAT_ZERO && !grant_valid)
    else $error("outputs not quiet after reset");

  c_load: cover property (wr_ld);
  c_flag_seen: cover property (rd_st ##1 reg_rdata[0]);
  c_grant: cover property (grant_valid && arb_advance);
endmodule

/* File: test/vcat_regs_tb_top.sv */
// testbench: table driven register and load checks, then flag, grant and reset cases
`timescale 1ns/10ps
module vcat_regs_tb_top
  import vcat_pkg::*;
  ;
  // one bus step: op 0 write, 1 read, 2 idle
  typedef struct packed {
    logic [1:0] op;
    logic [11:0] a;
    logic [31:0] d;
  } vcat_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] reg_addr = 12'h000;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic fc_init_pending = 1'b0;
  logic [1:0] egress_port = VCAT_PORT_B; // tied: port B plays the egress port
  logic arb_advance = 1'b0;
  logic grant_valid;
  logic [1:0] grant_port;
  int n_mismatch = 0;
  int checked = 0;
  int n = 0;
  logic [31:0] exp_g [3] = '{32'h0000_0000, 32'h0000_0002, 32'h0000_0000};
  // table 0xe4: A, B(egress), C, reserved, A
  vcat_row_t rows [20] = '{
    '{2'h1, VCAT_CTRL_OFS, 32'h8000_00ff}, '{2'h1, VCAT_STAT_OFS, 32'h0000_0000},
    '{2'h1, VCAT_TBL0_OFS, 32'h0000_0000}, '{2'h0, VCAT_CTRL_OFS, 32'h7f0e_ff00},
    '{2'h1, VCAT_CTRL_OFS, 32'h800e_0001}, '{2'h0, VCAT_TBL0_OFS, 32'hffff_f0e4},
    '{2'h1, VCAT_STAT_OFS, 32'h0000_0001}, '{2'h0, VCAT_STAT_OFS, 32'hffff_ffff},
    '{2'h1, VCAT_STAT_OFS, 32'h0000_0001}, '{2'h0, VCAT_TBL0_OFS, 32'hffff_f0e4},
    '{2'h1, VCAT_TBL0_OFS, 32'h0000_00e4}, '{2'h0, VCAT_CTRL_OFS, 32'h0000_0000},
    '{2'h2, 12'h000, 32'h0000_0000}, '{2'h1, VCAT_STAT_OFS, 32'h0000_0001},
    '{2'h0, 12'h1fc, 32'hffff_ffff}, '{2'h1, 12'h1fc, 32'h0000_0000},
    '{2'h0, VCAT_CTRL_OFS, 32'h0001_0000}, '{2'h2, 12'h000, 32'h0000_0000},
    '{2'h1, VCAT_STAT_OFS, 32'h0000_0000}, '{2'h1, VCAT_CTRL_OFS, 32'h8000_0001}};

  vcat_regs dut_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .fc_init_pending, .egress_port, .arb_advance, .grant_valid, .grant_port);

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  // compare and count; an unknown never matches
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobes are set once per step, so back-to-back steps never double-drive
  task automatic step(input logic [1:0] op, input logic [11:0] a, input logic [31:0] d);
    reg_wr <= (op == 2'h0);
    reg_rd <= (op == 2'h1);
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    step(2'h1, a, 32'h0000_0000);
    #1;
    chk("read data", reg_rdata, exp);
  endtask

  task automatic complete_run();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (rows[i]) begin
      if (rows[i].op == 2'h1) begin
        rd_chk(rows[i].a, rows[i].d);
      end else begin
        step(rows[i].op, rows[i].a, rows[i].d);
      end
    end
    // negotiation pending shows after the synchroniser settles
    fc_init_pending <= 1'b1;
    repeat (4) step(2'h2, 12'h000, 32'h0000_0000);
    rd_chk(VCAT_STAT_OFS, 32'h0000_0002);
    fc_init_pending <= 1'b0;
    // loaded table serves A, C, A; egress and reserved entries are skipped
    arb_advance <= 1'b1;
    for (int i = 0; i < 40 && n < 3; i++) begin
      step(2'h2, 12'h000, 32'h0000_0000);
      #1;
      if (grant_valid === 1'b1) begin
        chk("grant port", {30'h0000_0000, grant_port}, exp_g[n]);
        n++;
      end
    end
    if (n < 3) begin
      n_mismatch++;
      $display("unexpected grant count expected 3 seen %0d", n);
      complete_run();
    end
    // second reset in mid-run with the arbiter still busy
    rst <= 1'b1;
    repeat (2) step(2'h2, 12'h000, 32'h0000_0000);
    rst <= 1'b0;
    step(2'h2, 12'h000, 32'h0000_0000);
    rd_chk(VCAT_CTRL_OFS, 32'h8000_00ff);
    rd_chk(VCAT_TBL0_OFS, 32'h0000_0000);
    rd_chk(VCAT_STAT_OFS, 32'h0000_0000);
    step(2'h2, 12'h000, 32'h0000_0000);
    complete_run();
  end
endmodule

bind vcat_regs vcat_regs_chk chk_u (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .fc_init_pending, .egress_port, .arb_advance, .grant_valid, .grant_port);
